// [verilog/drq_params.svh]
// Constants for the reset and bus quiesce block
`ifndef DRQ_PARAMS_SVH
`define DRQ_PARAMS_SVH
`define DRQ_DATA_W 16
`define DRQ_ADDR_W 12
`define DRQ_PC_RESET 12'h000
`define DRQ_MIN_RESET_CYCLES 5
`define DRQ_SYNC_STAGES 2
`endif

// [verilog/drq_pkg.sv]
// Types shared by the reset and bus quiesce block
`include "drq_params.svh"
package drq_pkg;
  typedef logic [`DRQ_DATA_W-1:0] drq_data_t;
  typedef logic [`DRQ_ADDR_W-1:0] drq_addr_t;
  typedef enum logic [1:0] {DRQ_CYC_FETCH, DRQ_CYC_READ, DRQ_CYC_WRITE} drq_cyc_e;
  typedef struct packed {
    logic valid;
    drq_cyc_e kind;
    drq_addr_t addr;
    drq_data_t wdata;
  } drq_req_s;
  typedef struct packed {
    logic data_read_strobe_n;
    logic write_strobe_n;
    logic program_fetch_strobe_n;
  } drq_strobes_s;
endpackage

// [verilog/drq_reset_sync.sv]
// Two-stage synchroniser for the active-low reset pin
`timescale 1ns/100ps
`default_nettype none
module drq_reset_sync
  import drq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_in_low,
  output logic sync_reset
);
  logic meta;
  logic held;
  // Only the second stage reads meta
  always_ff @(posedge core_clk) begin
    meta <= ~reset_in_low;
    held <= meta;
  end
  assign sync_reset = held;
endmodule
`default_nettype wire

// [verilog/drq_reset_bus_quiesce.sv]
// Reset sequencing and bus quiesce for the external memory and I/O bus
//
// Notes on behaviour
// - During reset all three bus strobes are held inactive high.
// - During reset all sixteen data lines are released, enables low.
// - Address outputs and program counter clear to zero one full cycle after entry.
// - Fetching restarts at address zero one full cycle after reset rises.
// - Reset pin is synchronised; entry and exit latency can vary by a cycle.
// - At most one strobe is active in any bus cycle.
`timescale 1ns/100ps
`default_nettype none
`include "drq_params.svh"
module drq_reset_bus_quiesce
  import drq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_in_low,
  input wire drq_req_s core_req,
  output logic core_req_ready,
  output drq_addr_t program_counter,
  output logic core_run,
  output drq_addr_t address_bus_out,
  output drq_strobes_s bus_strobes,
  output drq_data_t data_out,
  output drq_data_t data_oe,
  input wire drq_data_t data_in,
  output drq_data_t read_data,
  output logic read_valid
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_RESET, ST_WAIT, ST_RUN} st_e;
  st_e state;
  st_e next_state;
  logic sync_reset;
  logic in_reset;
  logic reset_seen;
  logic take_req;
  logic read_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Request decoding shared by the address, strobe, data and capture logic

  function automatic logic is_fetch(input drq_req_s req);
    return req.valid && (req.kind == DRQ_CYC_FETCH);
  endfunction

  function automatic logic is_write(input drq_req_s req);
    return req.valid && (req.kind == DRQ_CYC_WRITE);
  endfunction

  // Fetches and data reads both bring a word back on the data lines
  function automatic logic wants_data(input drq_req_s req);
    return req.valid && (req.kind != DRQ_CYC_WRITE);
  endfunction

  // All strobes high is the quiet bus
  function automatic drq_strobes_s strobes_idle();
    drq_strobes_s s;
    s = '{1'b1, 1'b1, 1'b1};
    return s;
  endfunction

  // Exactly one strobe goes low for a taken request
  function automatic drq_strobes_s strobes_for(input drq_cyc_e kind);
    drq_strobes_s s;
    s = strobes_idle();
    unique case (kind)
      DRQ_CYC_FETCH: begin
        s.program_fetch_strobe_n = 1'b0;
      end
      DRQ_CYC_READ: begin
        s.data_read_strobe_n = 1'b0;
      end
      DRQ_CYC_WRITE: begin
        s.write_strobe_n = 1'b0;
      end
      default: begin
        s = strobes_idle();
      end
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset entry

  drq_reset_sync u_sync (
    .core_clk(core_clk),
    .reset_in_low(reset_in_low),
    .sync_reset(sync_reset)
  );

  // Core reset or the synchronised pin both quiesce the bus
  assign in_reset = rst | sync_reset;

  // Registered reset level; the address clear keys off it so that the clear
  // lands one full cycle after reset is seen
  always_ff @(posedge core_clk) begin
    reset_seen <= in_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ST_WAIT gives the one complete cycle after release before fetching

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET: begin
        if (!in_reset) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (in_reset) begin
          next_state = ST_RESET;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (in_reset) begin
          next_state = ST_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Ready is combinational so that reset withdraws it in the same cycle
  assign core_run = (state == ST_RUN) && !in_reset;
  assign core_req_ready = core_run;
  assign take_req = core_run && core_req.valid;

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and address outputs

  always_ff @(posedge core_clk) begin
    if (reset_seen || (state != ST_RUN)) begin
      program_counter <= `DRQ_PC_RESET;
    end else if (core_run && is_fetch(core_req)) begin
      program_counter <= program_counter + 12'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset_seen) begin
      address_bus_out <= `DRQ_PC_RESET;
    end else if (core_run && is_fetch(core_req)) begin
      address_bus_out <= program_counter;
    end else if (take_req) begin
      // A write in flight when reset hits may leave a stale address out
      address_bus_out <= core_req.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes and data drive are registered; reset wins the same cycle it is seen

  always_ff @(posedge core_clk) begin
    if (in_reset) begin
      bus_strobes <= strobes_idle();
    end else if (take_req) begin
      bus_strobes <= strobes_for(core_req.kind);
    end else begin
      bus_strobes <= strobes_idle();
    end
  end

  always_ff @(posedge core_clk) begin
    if (in_reset) begin
      data_oe <= 16'h0000;
    end else if (core_run && is_write(core_req)) begin
      data_oe <= 16'hffff;
    end else begin
      data_oe <= 16'h0000;
    end
  end

  // The word is held between writes; only the enables reach the pins
  always_ff @(posedge core_clk) begin
    if (in_reset) begin
      data_out <= 16'h0000;
    end else if (core_run && is_write(core_req)) begin
      data_out <= core_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured the cycle after a fetch or read strobe

  always_ff @(posedge core_clk) begin
    if (in_reset) begin
      read_pending <= 1'b0;
    end else begin
      read_pending <= core_run && wants_data(core_req);
    end
  end

  always_ff @(posedge core_clk) begin
    if (in_reset) begin
      read_valid <= 1'b0;
    end else begin
      read_valid <= read_pending;
    end
  end

  // Sampled at the edge that ends the strobe, while the far side still drives
  always_ff @(posedge core_clk) begin
    if (in_reset) begin
      read_data <= 16'h0000;
    end else if (read_pending) begin
      read_data <= data_in;
    end
  end
endmodule
`default_nettype wire

// [sim/drq_rbq_chk.sv]
// Assertions for the reset and bus quiesce block
`timescale 1ns/100ps
`default_nettype none
module drq_rbq_chk
  import drq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_in_low,
  input wire logic core_run,
  input wire logic core_req_ready,
  input wire logic read_valid,
  input wire drq_addr_t program_counter,
  input wire drq_addr_t address_bus_out,
  input wire drq_strobes_s bus_strobes,
  input wire drq_data_t data_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  strb_idle_a: assert property (!reset_in_low [*4] |-> bus_strobes == 3'h7)
    else $error("strobe low in reset");
  bus_float_a: assert property (!reset_in_low [*4] |-> data_oe == 16'h0000)
    else $error("bus driven in reset");
  addr_clr_a: assert property (!reset_in_low [*5] |-> {address_bus_out, program_counter} == 0)
    else $error("address not cleared");
  one_strobe_a: assert property ($countones(~{bus_strobes}) <= 1)
    else $error("two strobes low");
  run_quiet_a: assert property (!reset_in_low [*3] |-> !core_run && !core_req_ready)
    else $error("running in reset");
  sync_lat_a: assert property ($fell(reset_in_low) && core_run |=> core_run)
    else $error("reset not synchronised");
  resume_run_a: assert property ($rose(reset_in_low) |-> ##[1:5] core_run)
    else $error("no resume");
  fetch_zero_a: assert property ($rose(core_run) |-> program_counter == 0)
    else $error("resume not at zero");
  cover property ($rose(core_run));
  cover property (read_valid);
  cover property (!bus_strobes.write_strobe_n);
endmodule
bind drq_reset_bus_quiesce drq_rbq_chk u_drq_rbq_chk (.core_clk, .rst, .reset_in_low,
  .core_run, .core_req_ready, .read_valid, .program_counter, .address_bus_out,
  .bus_strobes, .data_oe);
`default_nettype wire

// [sim/drq_mem_model.sv]
// Behavioural external memory on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module drq_mem_model
  import drq_pkg::*;
(
  input wire logic core_clk,
  input wire drq_addr_t address_bus_out,
  input wire drq_strobes_s bus_strobes,
  input wire drq_data_t data_out,
  output drq_data_t data_in
);
  drq_data_t mem [0:15];
  logic tog = 1'b0;
  // Unselected bus toggles so a stale value can never pass
  assign data_in = (bus_strobes.data_read_strobe_n && bus_strobes.program_fetch_strobe_n) ?
    {16{tog}} : mem[address_bus_out[3:0]];
  always @(posedge core_clk) begin
    tog <= ~tog;
    // Takes any write, also one cut short by reset
    if (!bus_strobes.write_strobe_n) mem[address_bus_out[3:0]] <= data_out;
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Testbench for the reset and bus quiesce block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) check_count++; \
  if ((a) !== (b)) begin err_total++; $display("Error %0t %h %h", $time, a, b); end
module tb_top
  import drq_pkg::*;
;
  logic core_clk = 0, rst = 1, reset_in_low = 0, core_req_ready, core_run, read_valid;
  drq_req_s core_req = '0;
  drq_addr_t program_counter, address_bus_out;
  drq_strobes_s bus_strobes;
  drq_data_t data_out, data_oe, data_in, read_data;
  int err_total = 0, check_count = 0;
  drq_reset_bus_quiesce u_drq_reset_bus_quiesce (.core_clk, .rst, .reset_in_low, .core_req,
    .core_req_ready, .program_counter, .core_run, .address_bus_out, .bus_strobes,
    .data_out, .data_oe, .data_in, .read_data, .read_valid);
  drq_mem_model u_drq_mem_model (.core_clk, .address_bus_out, .bus_strobes, .data_out,
    .data_in);
  initial forever #5 core_clk = ~core_clk;
  task test_done;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_sig(input bit rv);
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      #1;
      if (rv ? read_valid : core_run) return;
    end
    err_total++;
    test_done();
  endtask
  task automatic req(input drq_cyc_e k, input drq_addr_t a, input drq_data_t d);
    @(negedge core_clk);
    core_req = '{1'b1, k, a, d};
    for (int i = 0; i < 20 && !core_req_ready; i++) @(negedge core_clk);
    if (!core_req_ready) begin
      err_total++;
      test_done();
    end
    @(negedge core_clk);
    core_req.valid = 1'b0;
  endtask
  task t_bus;
    req(DRQ_CYC_WRITE, 12'h000, 16'h1234);
    `CHK({bus_strobes, data_oe, data_out}, {3'h5, 16'hffff, 16'h1234})
    req(DRQ_CYC_WRITE, 12'h001, 16'hbeef);
    req(DRQ_CYC_FETCH, 12'h000, 16'h0000);
    `CHK({bus_strobes, address_bus_out, program_counter}, {3'h6, 12'h000, 12'h001})
    wait_sig(1);
    `CHK(read_data, 16'h1234)
    req(DRQ_CYC_READ, 12'h001, 16'h0000);
    `CHK({bus_strobes, address_bus_out}, {3'h3, 12'h001})
    wait_sig(1);
    `CHK(read_data, 16'hbeef)
  endtask
  task t_mid;
    @(negedge core_clk);
    core_req = '{1'b1, DRQ_CYC_WRITE, 12'h003, 16'h5a5a};
    @(negedge core_clk);
    // Reset lands while writes keep coming, so only reset can quiet the bus
    reset_in_low = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK({bus_strobes, data_oe, core_req_ready}, {3'h7, 16'h0000, 1'b0})
    core_req.valid = 1'b0;
    @(negedge core_clk);
    `CHK({address_bus_out, program_counter}, 24'h000000)
    repeat (2) @(negedge core_clk);
    reset_in_low = 1'b1; // Held six cycles
    wait_sig(0);
    `CHK(program_counter, 12'h000)
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    reset_in_low = 1'b1;
    wait_sig(0);
    t_bus;
    t_mid;
    t_bus;
    test_done;
  end
endmodule
`default_nettype wire
